// ### core/extension_enable_bit_pkg.sv
package ext_pkg;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 12;
	localparam int PC_W   = 21;
	localparam int WORD_W = 16;

	// opcode prefixes
	localparam logic [15:0] WORD_CALL_W    = 16'h0014;
	localparam logic [8:0]  PFX_MOVE_FILE  = 9'h1d6;
	localparam logic [8:0]  PFX_MOVE_IDX   = 9'h1d7;
	localparam logic [3:0]  PFX_SECOND     = 4'hf;
	localparam logic [7:0]  PFX_PUSH_LIT   = 8'hfa;
	localparam logic [7:0]  PFX_PTR_SUB    = 8'he9;
	localparam logic [1:0]  SEL_SUB_RETURN = 2'h3;

	// field positions
	localparam int OFS7_MSB = 6;
	localparam int OFS6_MSB = 5;
	localparam int SEL_LSB  = 6;
	localparam int ABIT_POS = 8;
	localparam int DBIT_POS = 9;

	// indexed literal offset limit for access-bank operands
	localparam logic [7:0] ILO_LIMIT = 8'h5f;

	// indirect data registers occupy these addresses (three pointers)
	localparam logic [11:0] INDF_BASE = 12'hfdb;
	localparam logic [11:0] INDF_SPAN = 12'h010;
	localparam logic [11:0] INDF_STEP = 12'h008;
	localparam logic [11:0] INDF_LOW  = 12'hfdb;
	localparam logic [11:0] ACCESS_HI = 12'hf00;

	localparam logic        EXT_EN_RESET = 1'b0;
	localparam logic [11:0] PTR_RESET   = 12'h000;
	localparam logic [20:0] PC_RESET    = 21'h000000;
	localparam logic [20:0] PC_STEP     = 21'h000002;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_SECOND_WORD,
		OP_MOVE_FILE,
		OP_MOVE_IDX,
		OP_PUSH_LIT,
		OP_PTR_SUB,
		OP_SUB_RETURN,
		OP_CALL_W
	} op_type;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_MOVE2,
		ST_FLUSH
	} state_type;
endpackage

// ### core/extension_enable_bit_bus_if.sv
`timescale 1ns/10ps
interface ext_bus_if;
	logic [15:0] insn;
	logic        ext_en;
	logic [7:0]  file_op;
	logic        abit;
	logic [11:0] frame_ptr;
	logic [3:0]  bank;
	ext_pkg::op_type op;
	logic [11:0] addr;
	logic        indexed;

	modport decoder (input insn, ext_en, file_op, abit, frame_ptr, bank,
		output op, addr, indexed);
	modport core (output insn, ext_en, file_op, abit, frame_ptr, bank,
		input op, addr, indexed);
endinterface

// ### core/extension_enable_bit_decode.sv
`timescale 1ns/10ps
module ext_decode (
	ext_bus_if.decoder bus
);
	import ext_pkg::*;

	always_comb begin
		bus.op = OP_NONE;
		if (bus.ext_en) begin
			if (bus.insn == WORD_CALL_W)
				bus.op = OP_CALL_W;
			else if (bus.insn[15:7] == PFX_MOVE_FILE)
				bus.op = OP_MOVE_FILE; // RULE2
			else if (bus.insn[15:7] == PFX_MOVE_IDX)
				bus.op = OP_MOVE_IDX; // RULE6
			else if (bus.insn[15:8] == PFX_PUSH_LIT)
				bus.op = OP_PUSH_LIT; // RULE9
			else if (bus.insn[15:8] == PFX_PTR_SUB)
				bus.op = (bus.insn[7:6] == SEL_SUB_RETURN) ? OP_SUB_RETURN : OP_PTR_SUB; // RULE11
			else if (bus.insn[15:12] == PFX_SECOND)
				bus.op = OP_SECOND_WORD; // RULE8
		end
	end

	// address formation for standard byte and bit operands
	always_comb begin
		bus.indexed = bus.ext_en && !bus.abit && (bus.file_op <= ILO_LIMIT); // RULE13 RULE15
		if (bus.indexed)
			bus.addr = bus.frame_ptr + {4'h0, bus.file_op}; // RULE15
		else if (bus.abit)
			bus.addr = {bus.bank, bus.file_op}; // RULE14
		else if (bus.file_op[7])
			bus.addr = ACCESS_HI | {4'h0, bus.file_op}; // RULE17
		else
			bus.addr = {4'h0, bus.file_op}; // RULE14
	end
endmodule

// ### core/extension_enable_bit_exec.sv
`timescale 1ns/10ps
// Behaviour
// [RULE1] call via w pushes pc+2, loads pc
// [RULE2] indexed-to-file source is frame pointer plus offset
// [RULE3] indexed-to-file destination is second word field
// [RULE4] software avoids pc and stack-top destinations
// [RULE5] indirect register source reads as zero
// [RULE6] indexed-to-indexed both addresses frame-relative
// [RULE7] indirect destination makes indexed move a nop
// [RULE8] indexed moves two cycles; stray second word nops
// [RULE9] push literal stores then decrements frame pointer
// [RULE10] pointer subtract six-bit literal, flags untouched
// [RULE11] select three subtracts frame pointer and returns
// [RULE12] subtract-and-return second cycle is nop
// [RULE13] extension enable also enables indexed offsets
// [RULE14] disabled: access bank or banked absolute address
// [RULE15] enabled, a=0, operand <=5fh is frame offset
// [RULE16] destination bit keeps w or file meaning
// [RULE17] operands above 5fh stay absolute access bank
// [RULE18] extension enable defaults to zero
module ext_exec (
	input  wire logic                  mclk,
	input  wire logic                  arst_n,
	input  wire logic                  cfg_ext_enable,
	input  wire logic                  cfg_load,
	input  wire logic [15:0]           insn,
	input  wire logic                  insn_valid,
	input  wire logic [7:0]            working_register,
	input  wire logic [7:0]            pc_latch_high,
	input  wire logic [7:0]            pc_latch_upper,
	input  wire logic [20:0]           pc_now,
	input  wire logic [20:0]           return_stack_top,
	input  wire logic [3:0]            bank_select_register,
	input  wire logic [7:0]            rd_data,
	output logic [11:0]                rd_addr,
	output logic                       rd_en,
	output logic [11:0]                wr_addr,
	output logic [7:0]                 wr_data,
	output logic                       wr_en,
	output logic                       wr_to_w,
	output logic                       push_en,
	output logic [20:0]                push_value,
	output logic                       pop_en,
	output logic                       pc_load,
	output logic [20:0]                pc_value,
	output logic                       flush,
	output logic                       std_indexed,
	output logic [11:0]                std_addr,
	output logic                       ext_enabled,
	output logic [11:0]                ptr0,
	output logic [11:0]                ptr1,
	output logic [11:0]                stack_frame_pointer
);
	import ext_pkg::*;

	function automatic logic is_indirect(input logic [11:0] a);
		is_indirect = (a >= INDF_LOW) && (a < INDF_LOW + INDF_SPAN + INDF_STEP);
	endfunction

	function automatic logic [11:0] frame_rel(input logic [11:0] fp, input logic [6:0] ofs);
		frame_rel = fp + {5'h00, ofs};
	endfunction

	ext_bus_if bus ();
	ext_decode u_dec (
		.bus (bus)
	);

	logic              ext_en_ff, nxt_ext_en;
	logic [11:0]       ptr_ff [3];
	logic [11:0]       nxt_ptr [3];
	state_type         state_ff, nxt_state;
	logic              move_idx_ff, nxt_move_idx;
	logic [11:0]       rd_addr_ff, nxt_rd_addr;
	logic              rd_en_ff, nxt_rd_en;
	logic [11:0]       wr_addr_ff, nxt_wr_addr;
	logic [7:0]        wr_data_ff, nxt_wr_data;
	logic              wr_en_ff, nxt_wr_en;
	logic              push_ff, nxt_push;
	logic [20:0]       push_val_ff, nxt_push_val;
	logic              pop_ff, nxt_pop;
	logic              pc_load_ff, nxt_pc_load;
	logic [20:0]       pc_val_ff, nxt_pc_val;
	logic              src_zero_ff, nxt_src_zero;

	assign bus.insn      = insn;
	assign bus.ext_en    = ext_en_ff;
	assign bus.file_op   = insn[7:0];
	assign bus.abit      = insn[ABIT_POS];
	assign bus.frame_ptr = ptr_ff[2];
	assign bus.bank      = bank_select_register;

	assign std_indexed = bus.indexed;
	assign std_addr    = bus.addr;
	assign wr_to_w     = !insn[DBIT_POS]; // RULE16
	assign ext_enabled = ext_en_ff;
	assign ptr0        = ptr_ff[0];
	assign ptr1        = ptr_ff[1];
	assign stack_frame_pointer = ptr_ff[2];
	assign rd_addr     = rd_addr_ff;
	assign rd_en       = rd_en_ff;
	assign wr_addr     = wr_addr_ff;
	assign wr_data     = wr_data_ff;
	assign wr_en       = wr_en_ff;
	assign push_en     = push_ff;
	assign push_value  = push_val_ff;
	assign pop_en      = pop_ff;
	assign pc_load     = pc_load_ff;
	assign pc_value    = pc_val_ff;
	assign flush       = (state_ff == ST_FLUSH);

	always_comb begin
		nxt_ext_en   = ext_en_ff;
		nxt_ptr      = ptr_ff;
		nxt_state    = state_ff;
		nxt_move_idx = move_idx_ff;
		nxt_rd_addr  = rd_addr_ff;
		nxt_rd_en    = 1'b0;
		nxt_wr_addr  = wr_addr_ff;
		nxt_wr_data  = wr_data_ff;
		nxt_wr_en    = 1'b0;
		nxt_push     = 1'b0;
		nxt_push_val = push_val_ff;
		nxt_pop      = 1'b0;
		nxt_pc_load  = 1'b0;
		nxt_pc_val   = pc_val_ff;
		nxt_src_zero = src_zero_ff;
		if (cfg_load)
			nxt_ext_en = cfg_ext_enable; // RULE13
		case (state_ff)
		ST_RUN: begin
			if (insn_valid) begin
				case (bus.op)
				OP_CALL_W: begin
					nxt_push     = 1'b1; // RULE1
					nxt_push_val = pc_now + PC_STEP;
					nxt_pc_load  = 1'b1;
					nxt_pc_val   = {pc_latch_upper[4:0], pc_latch_high, working_register};
					nxt_state    = ST_FLUSH;
				end
				OP_MOVE_FILE, OP_MOVE_IDX: begin
					nxt_rd_addr  = frame_rel(ptr_ff[2], insn[OFS7_MSB:0]); // RULE2 RULE6
					nxt_src_zero = is_indirect(frame_rel(ptr_ff[2], insn[OFS7_MSB:0])); // RULE5
					nxt_rd_en    = !is_indirect(frame_rel(ptr_ff[2], insn[OFS7_MSB:0]));
					nxt_move_idx = (bus.op == OP_MOVE_IDX);
					nxt_state    = ST_MOVE2; // RULE8
				end
				OP_PUSH_LIT: begin
					nxt_wr_addr = ptr_ff[2]; // RULE9
					nxt_wr_data = insn[7:0];
					nxt_wr_en   = 1'b1;
					nxt_ptr[2]  = ptr_ff[2] - 12'h001;
				end
				OP_PTR_SUB: begin
					nxt_ptr[insn[7:6]] = ptr_ff[insn[7:6]] - {6'h00, insn[OFS6_MSB:0]}; // RULE10
				end
				OP_SUB_RETURN: begin
					nxt_ptr[2]  = ptr_ff[2] - {6'h00, insn[OFS6_MSB:0]}; // RULE11
					nxt_pop     = 1'b1;
					nxt_pc_load = 1'b1;
					nxt_pc_val  = return_stack_top;
					nxt_state   = ST_FLUSH; // RULE12
				end
				default: begin
				end
				endcase
			end
		end
		ST_MOVE2: begin
			// source data arrives during this cycle
			if (insn_valid) begin
				nxt_wr_data = src_zero_ff ? 8'h00 : rd_data;
				if (move_idx_ff) begin
					nxt_wr_addr = frame_rel(ptr_ff[2], insn[OFS7_MSB:0]); // RULE6
					nxt_wr_en   = !is_indirect(frame_rel(ptr_ff[2], insn[OFS7_MSB:0])); // RULE7
				end else begin
					nxt_wr_addr = insn[11:0]; // RULE3
					nxt_wr_en   = 1'b1;
				end
				nxt_state = ST_RUN; // RULE8
			end
		end
		ST_FLUSH: begin
			nxt_state = ST_RUN; // RULE1 RULE12
		end
		default: nxt_state = ST_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ext_en_ff   <= EXT_EN_RESET; // RULE18
			ptr_ff      <= '{PTR_RESET, PTR_RESET, PTR_RESET};
			state_ff    <= ST_RUN;
			move_idx_ff <= 1'b0;
			rd_addr_ff  <= 12'h000;
			rd_en_ff    <= 1'b0;
			wr_addr_ff  <= 12'h000;
			wr_data_ff  <= 8'h00;
			wr_en_ff    <= 1'b0;
			push_ff     <= 1'b0;
			push_val_ff <= PC_RESET;
			pop_ff      <= 1'b0;
			pc_load_ff  <= 1'b0;
			pc_val_ff   <= PC_RESET;
			src_zero_ff <= 1'b0;
		end else begin
			ext_en_ff   <= nxt_ext_en;
			ptr_ff      <= nxt_ptr;
			state_ff    <= nxt_state;
			move_idx_ff <= nxt_move_idx;
			rd_addr_ff  <= nxt_rd_addr;
			rd_en_ff    <= nxt_rd_en;
			wr_addr_ff  <= nxt_wr_addr;
			wr_data_ff  <= nxt_wr_data;
			wr_en_ff    <= nxt_wr_en;
			push_ff     <= nxt_push;
			push_val_ff <= nxt_push_val;
			pop_ff      <= nxt_pop;
			pc_load_ff  <= nxt_pc_load;
			pc_val_ff   <= nxt_pc_val;
			src_zero_ff <= nxt_src_zero;
		end
	end

	// the nop cycle of a two-cycle instruction is the one in which flush stands
	sequence s_call_w;
		insn_valid && state_ff == ST_RUN && bus.op == OP_CALL_W;
	endsequence

	sequence s_sub_return;
		insn_valid && state_ff == ST_RUN && bus.op == OP_SUB_RETURN;
	endsequence

	sequence s_move_first;
		insn_valid && state_ff == ST_RUN && (bus.op == OP_MOVE_FILE || bus.op == OP_MOVE_IDX);
	endsequence

	a_call_push: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
		s_call_w |=> push_en && pc_load && flush
		&& push_value == $past(pc_now) + PC_STEP ##1 !flush)
		else $error("call via w push or jump missing");

	a_call_target: assert property (@(posedge mclk) disable iff (!arst_n) // RULE1
		s_call_w |=> pc_value == {$past(pc_latch_upper[4:0]), $past(pc_latch_high),
		$past(working_register)})
		else $error("call via w target wrong");

	a_push_write: assert property (@(posedge mclk) disable iff (!arst_n) // RULE9
		insn_valid && state_ff == ST_RUN && bus.op == OP_PUSH_LIT
		|=> wr_en && wr_addr == $past(ptr_ff[2])
		&& stack_frame_pointer == $past(ptr_ff[2]) - 12'h001)
		else $error("push literal wrong");

	a_sub_return: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
		s_sub_return |=> pop_en && pc_load && flush
		&& pc_value == $past(return_stack_top) ##1 !flush)
		else $error("subtract and return wrong");

	a_sub_frame: assert property (@(posedge mclk) disable iff (!arst_n) // RULE11
		s_sub_return |=> stack_frame_pointer == $past(ptr_ff[2]) - {6'h00, $past(insn[5:0])})
		else $error("subtract and return pointer wrong");

	a_flush_idle: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
		flush |-> !wr_en && !rd_en ##1 !flush)
		else $error("flush cycle not a nop");

	a_flush_ignore: assert property (@(posedge mclk) disable iff (!arst_n) // RULE12
		flush && insn_valid |=> !wr_en && !rd_en && !push_en && !pc_load && !flush)
		else $error("word taken during flush cycle");

	a_move_two: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
		s_move_first |=> state_ff == ST_MOVE2)
		else $error("indexed move not two cycles");

	a_move_src: assert property (@(posedge mclk) disable iff (!arst_n) // RULE2
		s_move_first |=> rd_addr == $past(ptr_ff[2]) + {5'h00, $past(insn[6:0])})
		else $error("indexed move source address wrong");

	a_move_data: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
		insn_valid && state_ff == ST_MOVE2 && !src_zero_ff |=> wr_data == $past(rd_data))
		else $error("indexed move data wrong");

	a_src_zero: assert property (@(posedge mclk) disable iff (!arst_n) // RULE5
		insn_valid && state_ff == ST_MOVE2 && src_zero_ff |=> wr_data == 8'h00)
		else $error("indirect source not zero");

	a_file_dest: assert property (@(posedge mclk) disable iff (!arst_n) // RULE3
		insn_valid && state_ff == ST_MOVE2 && !move_idx_ff
		|=> wr_en && wr_addr == $past(insn[11:0]))
		else $error("indexed to file destination wrong");

	a_idx_dest: assert property (@(posedge mclk) disable iff (!arst_n) // RULE6
		insn_valid && state_ff == ST_MOVE2 && move_idx_ff
		&& !is_indirect(ptr_ff[2] + {5'h00, insn[6:0]})
		|=> wr_en && wr_addr == $past(ptr_ff[2]) + {5'h00, $past(insn[6:0])})
		else $error("indexed to indexed destination wrong");

	a_dest_nop: assert property (@(posedge mclk) disable iff (!arst_n) // RULE7
		insn_valid && state_ff == ST_MOVE2 && move_idx_ff
		&& is_indirect(ptr_ff[2] + {5'h00, insn[6:0]}) |=> !wr_en)
		else $error("indirect destination written");

	a_stray_nop: assert property (@(posedge mclk) disable iff (!arst_n) // RULE8
		insn_valid && state_ff == ST_RUN && bus.op == OP_SECOND_WORD
		|=> !wr_en && !rd_en && state_ff == ST_RUN)
		else $error("stray second word executed");

	a_ptr_sub: assert property (@(posedge mclk) disable iff (!arst_n) // RULE10
		insn_valid && state_ff == ST_RUN && bus.op == OP_PTR_SUB && insn[7:6] == 2'h0
		|=> ptr0 == $past(ptr_ff[0]) - {6'h00, $past(insn[5:0])}
		&& $stable(stack_frame_pointer))
		else $error("pointer subtract wrong");

	a_ilo_addr: assert property (@(posedge mclk) disable iff (!arst_n) // RULE15
		std_indexed |-> ext_enabled && std_addr == stack_frame_pointer + {4'h0, insn[7:0]})
		else $error("indexed offset address wrong");

	a_upper_abs: assert property (@(posedge mclk) disable iff (!arst_n) // RULE17
		!insn[ABIT_POS] && insn[7] |-> !std_indexed && std_addr == {4'hf, insn[7:0]})
		else $error("upper access bank not absolute");

	a_disabled_abs: assert property (@(posedge mclk) disable iff (!arst_n) // RULE14
		!ext_enabled |-> !std_indexed && bus.op == OP_NONE)
		else $error("extension active while disabled");

	a_config_hold: assert property (@(posedge mclk) disable iff (!arst_n) // RULE13
		!cfg_load |=> $stable(ext_enabled))
		else $error("extension enable changed without load");
endmodule

// ### sim/tb.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end
module tb;
	import ext_pkg::*;
	logic        mclk = 1'b0;
	logic        arst_n = 1'b0;
	logic        cfg_ext_enable = 1'b0;
	logic        cfg_load = 1'b0;
	logic [15:0] insn = 16'h0000;
	logic        insn_valid = 1'b0;
	logic [7:0]  working_register = 8'h00;
	logic [7:0]  pc_latch_high = 8'h00;
	logic [7:0]  pc_latch_upper = 8'h00;
	logic [20:0] pc_now = 21'h000000;
	logic [20:0] return_stack_top = 21'h000000;
	logic [3:0]  bank_select_register = 4'h0;
	logic [7:0]  rd_data = 8'h00;
	logic [11:0] rd_addr, wr_addr, std_addr, ptr0, ptr1, stack_frame_pointer;
	logic [7:0]  wr_data;
	logic        rd_en, wr_en, wr_to_w, push_en, pop_en, pc_load, flush;
	logic        std_indexed, ext_enabled;
	logic [20:0] push_value, pc_value;
	int          bad_count = 0;
	int          n_compared = 0;
	logic [11:0] fp, p0, p1, wa;
	logic [7:0]  k, d;

	ext_exec DUT (.mclk, .arst_n, .cfg_ext_enable, .cfg_load, .insn, .insn_valid,
		.working_register, .pc_latch_high, .pc_latch_upper, .pc_now, .return_stack_top,
		.bank_select_register, .rd_data, .rd_addr, .rd_en, .wr_addr, .wr_data, .wr_en,
		.wr_to_w, .push_en, .push_value, .pop_en, .pc_load, .pc_value, .flush,
		.std_indexed, .std_addr, .ext_enabled, .ptr0, .ptr1, .stack_frame_pointer);

	always #5 mclk = ~mclk;

	function automatic logic [11:0] exp_std(logic en, logic a, logic [7:0] op,
		logic [11:0] f, logic [3:0] b);
		if (a)
			return {b, op};
		if (en && op <= ILO_LIMIT)
			return f + {4'h0, op};
		return (op > 8'h7f) ? {4'hf, op} : {4'h0, op};
	endfunction

	task automatic print_verdict();
		if (bad_count == 0 && n_compared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic run(input logic [15:0] w);
		insn = w;
		insn_valid = 1'b1;
		@(posedge mclk);
		#1;
	endtask

	task automatic idle();
		insn_valid = 1'b0;
		@(posedge mclk);
		#1;
	endtask

	// standard byte operands, boundary values first, then random ones
	task automatic std_chk(input logic en);
		logic [7:0] op;
		logic       a;
		logic       dbit;
		for (int j = 0; j < 6; j++) begin
			op = (j == 0) ? 8'h5f : (j == 1) ? 8'h60 : 8'($urandom);
			a = (j < 2) ? 1'b0 : 1'($urandom);
			dbit = 1'($urandom);
			insn = {6'h09, dbit, a, op};
			bank_select_register = 4'($urandom);
			#2;
			`CHK(std_addr, exp_std(en, a, op, fp, bank_select_register))
			`CHK(std_indexed, !a && en && op <= ILO_LIMIT)
			`CHK(wr_to_w, !dbit)
			@(posedge mclk);
			#1;
		end
	endtask

	task automatic move(input logic [15:0] w1, input logic [15:0] w2, input logic [11:0] src,
		input logic we, input logic [11:0] wadr, input logic [7:0] rd, input logic [7:0] wd);
		run(w1);
		`CHK(rd_addr, src)
		`CHK(rd_en, !((src >= INDF_LOW) && (src < INDF_LOW + INDF_SPAN + INDF_STEP)))
		rd_data = rd;
		run(w2);
		`CHK(wr_en, we)
		if (we) begin
			`CHK(wr_addr, wadr)
			`CHK(wr_data, wd)
		end
		idle();
	endtask

	initial begin
		void'($urandom(32'ha19f9e98));
		repeat (6) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		fp = 12'h000;
		p0 = 12'h000;
		p1 = 12'h000;
		`CHK(ext_enabled, 1'b0)
		`CHK(stack_frame_pointer, 12'h000)
		run({PFX_PUSH_LIT, 8'h5a});
		`CHK(wr_en, 1'b0)
		idle();
		std_chk(1'b0);
		cfg_ext_enable = 1'b1;
		cfg_load = 1'b1;
		@(posedge mclk);
		#1;
		cfg_load = 1'b0;
		`CHK(ext_enabled, 1'b1)
		// two pushes back to back, the second sees the decremented pointer
		for (int i = 0; i < 2; i++) begin
			k = 8'($urandom);
			run({PFX_PUSH_LIT, k});
			`CHK(wr_en, 1'b1)
			`CHK(wr_addr, fp)
			`CHK(wr_data, k)
			fp = fp - 12'h001;
			`CHK(stack_frame_pointer, fp)
		end
		return_stack_top = 21'($urandom);
		run({PFX_PTR_SUB, SEL_SUB_RETURN, 6'h1e});
		fp = fp - 12'h01e;
		`CHK(stack_frame_pointer, fp)
		`CHK(pop_en, 1'b1)
		`CHK(pc_load, 1'b1)
		`CHK(pc_value, return_stack_top)
		`CHK(flush, 1'b1)
		// a word offered in the nop cycle is dropped
		run({PFX_PUSH_LIT, 8'ha5});
		`CHK(wr_en, 1'b0)
		`CHK(stack_frame_pointer, fp)
		`CHK(flush, 1'b0)
		idle();
		std_chk(1'b1);
		d = 8'($urandom);
		// frame pointer now sits inside the indirect register window
		move({PFX_MOVE_FILE, 7'h05}, {PFX_SECOND, 12'h123}, 12'hfe5, 1'b1, 12'h123, d, 8'h00);
		wa = 12'($urandom) & 12'h7ff;
		move({PFX_MOVE_FILE, 7'h7f}, {PFX_SECOND, wa}, 12'h05f, 1'b1, wa, d, d);
		move({PFX_MOVE_IDX, 7'h7f}, {PFX_SECOND, 5'h00, 7'h0a}, 12'h05f, 1'b0, 12'h000, d, d);
		move({PFX_MOVE_IDX, 7'h7f}, {PFX_SECOND, 5'h1f, 7'h21}, 12'h05f, 1'b1, 12'h001, d, d);
		run(16'hf0a5);
		`CHK(wr_en, 1'b0)
		for (int i = 0; i < 3; i++) begin
			k = 8'($urandom) & 8'h3f;
			run({PFX_PTR_SUB, 2'(i), k[5:0]});
			case (i)
				0: p0 = p0 - {4'h0, k};
				1: p1 = p1 - {4'h0, k};
				default: fp = fp - {4'h0, k};
			endcase
			`CHK(ptr0, p0)
			`CHK(ptr1, p1)
			`CHK(stack_frame_pointer, fp)
		end
		pc_now = 21'($urandom) & 21'h1ffffe;
		working_register = 8'($urandom);
		pc_latch_high = 8'($urandom);
		pc_latch_upper = 8'($urandom);
		run(WORD_CALL_W);
		`CHK(push_en, 1'b1)
		`CHK(push_value, pc_now + 21'h000002)
		`CHK(pc_load, 1'b1)
		`CHK(pc_value, {pc_latch_upper[4:0], pc_latch_high, working_register})
		`CHK(flush, 1'b1)
		idle();
		`CHK(flush, 1'b0)
		`CHK(push_en, 1'b0)
		// turning the extension off again drops the indexed forms
		cfg_ext_enable = 1'b0;
		cfg_load = 1'b1;
		@(posedge mclk);
		#1;
		cfg_load = 1'b0;
		`CHK(ext_enabled, 1'b0)
		std_chk(1'b0);
		run({PFX_PUSH_LIT, 8'h3c});
		`CHK(wr_en, 1'b0)
		idle();
		print_verdict();
	end

	// the whole sequence needs well under a thousand cycles
	initial begin
		#100000;
		bad_count++;
		print_verdict();
	end
endmodule
